/* File: design/host_bus_byte_lane_port.sv */
// host bus port: address latch, strobes, ready, lane steering, local decode
`timescale 1ns/1ps
`include "host_port_defines.svh"
module host_bus_byte_lane_port
    import host_port_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic MODE16,
    input wire logic [15:1] ADDR,
    input wire logic IO_QUALIFY_N,
    input wire logic [3:0] BYTE_ENABLE_N,
    input wire logic ADDR_STROBE_N,
    input wire logic READ_STROBE_N,
    input wire logic WRITE_STROBE_N,
    input wire logic [31:0] DATA_IN,
    output logic [31:0] DATA_OUT,
    output logic [3:0] DATA_OE_N,
    output logic ASYNC_READY_OUT,
    output logic LOCAL_DEVICE_DECODE_N,
    input wire logic CORE_BUSY,
    input wire logic [31:0] CORE_RD_DATA,
    output logic [15:1] CORE_ADDR,
    output logic [31:0] CORE_WR_DATA,
    output logic [3:0] CORE_WR_LANES,
    output logic CORE_WR_STROBE,
    output xfer_size_t XFER_SIZE
);
    addr_phase_t live;
    addr_phase_t held;
    addr_phase_t cur;
    lane_sel_t sel;
    port_state_t s_reg;
    port_state_t s_next;
    logic qualified;
    logic in_access;
    logic [3:0] rd_lanes_live;

    assign live.addr = ADDR;
    assign live.io_qualify_n = IO_QUALIFY_N;
    assign live.byte_enable_n = BYTE_ENABLE_N;

    // transparent latch on purpose: the strobe is the bus's own timing
    always_latch begin
        if (!ADDR_STROBE_N) begin
            held <= live;
        end
    end

    // a grounded strobe keeps the latch open, so decode tracks the pins
    assign cur = ADDR_STROBE_N ? held : live;

    byte_lane_decode u_decode (
        .mode16(MODE16),
        .be_n(cur.byte_enable_n),
        .sel(sel)
    );

    assign qualified = !cur.io_qualify_n;
    assign LOCAL_DEVICE_DECODE_N =
        !(qualified && cur.addr[`ADDR_HI_MSB:`ADDR_HI_LSB] == `BASE_ADDR_HI);
    assign in_access = qualified && !LOCAL_DEVICE_DECODE_N;

    // ready falls combinationally with the strobe, so the host sees it in time
    assign ASYNC_READY_OUT = !(in_access && CORE_BUSY
        && (!READ_STROBE_N || !WRITE_STROBE_N)) && s_reg.ready;

    // lanes 2,3 never enabled in 16-bit mode since the decoder masks them
    assign rd_lanes_live = (in_access && !READ_STROBE_N) ? sel.lanes : 4'h0;
    assign DATA_OE_N = ~rd_lanes_live;
    assign DATA_OUT = s_reg.rd_data;

    assign CORE_ADDR = s_reg.wr_addr;
    assign CORE_WR_DATA = s_reg.wr_data;
    assign CORE_WR_LANES = s_reg.wr_lanes;
    assign CORE_WR_STROBE = s_reg.wr_pulse;
    assign XFER_SIZE = sel.size;

    always_comb begin
        s_next = s_reg;
        s_next.wr_pulse = 1'b0;
        s_next.rd_sync1 = !READ_STROBE_N;
        s_next.rd_sync2 = s_reg.rd_sync1;
        s_next.wr_sync1 = !WRITE_STROBE_N;
        s_next.wr_sync2 = s_reg.wr_sync1;
        // edge found past the second stage, so the edge logic reads only wr_sync2 and wr_sync3
        s_next.wr_sync3 = s_reg.wr_sync2;
        s_next.rd_lanes = rd_lanes_live;
        // read data held per lane; floating lanes keep old value
        for (int i = 0; i < 4; i++) begin
            if (rd_lanes_live[i]) begin
                s_next.rd_data[i*8 +: 8] = CORE_RD_DATA[i*8 +: 8];
            end
        end
        // capture while the strobe is low; last value stands at its trailing edge
        if (in_access && !WRITE_STROBE_N) begin
            for (int i = 0; i < 4; i++) begin
                if (sel.lanes[i]) begin
                    s_next.wr_data[i*8 +: 8] = DATA_IN[i*8 +: 8];
                end
            end
            s_next.wr_lanes = sel.lanes;
            s_next.wr_addr = cur.addr;
        end
        if (s_reg.wr_sync3 && !s_reg.wr_sync2) begin
            s_next.wr_pulse = 1'b1;
        end
        case (s_reg.state)
            ST_IDLE: begin
                s_next.ready = 1'b1;
                if ((s_reg.rd_sync2 || s_reg.wr_sync2) && CORE_BUSY) begin
                    s_next.state = ST_WAIT;
                    s_next.ready = 1'b0;
                    s_next.wait_cnt = `RDY_WAIT_CYCLES;
                end
            end
            ST_WAIT: begin
                s_next.ready = 1'b0;
                if (CORE_BUSY) begin
                    s_next.wait_cnt = `RDY_WAIT_CYCLES;
                end else if (s_reg.wait_cnt != 4'h0) begin
                    s_next.wait_cnt = s_reg.wait_cnt - 4'h1;
                end else begin
                    s_next.state = ST_DONE;
                    s_next.ready = 1'b1;
                end
            end
            ST_DONE: begin
                s_next.ready = 1'b1;
                if (!s_reg.rd_sync2 && !s_reg.wr_sync2) begin
                    s_next.state = ST_IDLE;
                end
            end
            default: begin
                s_next.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            s_reg <= '0;
            s_reg.state <= ST_IDLE;
            s_reg.ready <= 1'b1;
            s_reg.rd_data <= `DATA_RESET;
            s_reg.wr_data <= `DATA_RESET;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

/* File: design/host_port_defines.svh */
// constants for the host bus byte lane port
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH
`define BASE_ADDR_HI 12'h030
`define ADDR_HI_MSB 15
`define ADDR_HI_LSB 4
`define RDY_WAIT_CYCLES 4'h2
`define DATA_RESET 32'h0000_0000
`endif

/* File: design/host_port_pkg.sv */
// types for the host bus byte lane port
package host_port_pkg;
    typedef enum logic [2:0] {
        XFER_NONE,
        XFER_BYTE,
        XFER_WORD,
        XFER_DWORD,
        XFER_BAD
    } xfer_size_t;

    typedef struct packed {
        logic [15:1] addr;
        logic io_qualify_n;
        logic [3:0] byte_enable_n;
    } addr_phase_t;

    typedef struct packed {
        logic [3:0] lanes;
        xfer_size_t size;
    } lane_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_DONE
    } access_state_t;

    typedef struct packed {
        access_state_t state;
        logic [3:0] wait_cnt;
        logic ready;
        logic [31:0] wr_data;
        logic [3:0] wr_lanes;
        logic [15:1] wr_addr;
        logic wr_pulse;
        logic rd_sync1;
        logic rd_sync2;
        logic wr_sync1;
        logic wr_sync2;
        logic wr_sync3;
        logic [31:0] rd_data;
        logic [3:0] rd_lanes;
    } port_state_t;
endpackage

/* File: design/byte_lane_decode.sv */
// byte enable to lane decoder
`timescale 1ns/1ps
module byte_lane_decode
    import host_port_pkg::*;
(
    input wire logic mode16,
    input wire logic [3:0] be_n,
    output lane_sel_t sel
);
    always_comb begin
        sel.lanes = 4'h0;
        sel.size = XFER_BAD;
        if (mode16) begin
            // upper pair tied high in this hookup
            case (be_n[1:0])
                2'b00: begin
                    sel.lanes = 4'h3;
                    sel.size = XFER_WORD;
                end
                2'b10: begin
                    sel.lanes = 4'h1;
                    sel.size = XFER_BYTE;
                end
                2'b01: begin
                    sel.lanes = 4'h2;
                    sel.size = XFER_BYTE;
                end
                default: begin
                    sel.lanes = 4'h0;
                    sel.size = XFER_NONE;
                end
            endcase
        end else begin
            case (be_n)
                4'h0: begin
                    sel.lanes = 4'hf;
                    sel.size = XFER_DWORD;
                end
                4'hc: begin
                    sel.lanes = 4'h3;
                    sel.size = XFER_WORD;
                end
                4'h3: begin
                    sel.lanes = 4'hc;
                    sel.size = XFER_WORD;
                end
                4'he, 4'hd, 4'hb, 4'h7: begin
                    sel.lanes = ~be_n;
                    sel.size = XFER_BYTE;
                end
                4'hf: begin
                    sel.lanes = 4'h0;
                    sel.size = XFER_NONE;
                end
                default: begin
                    sel.lanes = 4'h0;
                    sel.size = XFER_BAD;
                end
            endcase
        end
    end
endmodule

/* File: sim/host_port_sva.sv */
// assertions on the host bus byte lane port
`timescale 1ns/1ps
`include "host_port_defines.svh"
module host_port_sva (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic MODE16,
    input wire logic [15:1] ADDR,
    input wire logic IO_QUALIFY_N,
    input wire logic [3:0] BYTE_ENABLE_N,
    input wire logic ADDR_STROBE_N,
    input wire logic READ_STROBE_N,
    input wire logic WRITE_STROBE_N,
    input wire logic [3:0] DATA_OE_N,
    input wire logic ASYNC_READY_OUT,
    input wire logic LOCAL_DEVICE_DECODE_N,
    input wire logic CORE_BUSY,
    input wire logic CORE_WR_STROBE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // live decode only, so it says nothing while the latch is closed
    wire hit = !ADDR_STROBE_N && !IO_QUALIFY_N && ADDR[15:4] == `BASE_ADDR_HI;
    property p_dec; !ADDR_STROBE_N |-> LOCAL_DEVICE_DECODE_N == !hit; endproperty
    a_dec: assert property (p_dec) else $error("decode");
    property p_ref; IO_QUALIFY_N && !ADDR_STROBE_N |-> &DATA_OE_N; endproperty
    a_ref: assert property (p_ref) else $error("refused");
    property p_l16; MODE16 && !READ_STROBE_N && hit |-> DATA_OE_N == (BYTE_ENABLE_N | 4'hc);
    endproperty
    a_l16: assert property (p_l16) else $error("lanes");
    property p_rdy; $fell(READ_STROBE_N) && CORE_BUSY && hit |-> !ASYNC_READY_OUT; endproperty
    a_rdy: assert property (p_rdy) else $error("ready");
    property p_rise; !ASYNC_READY_OUT && $fell(CORE_BUSY) |-> ##[1:4] ASYNC_READY_OUT;
    endproperty
    a_rise: assert property (p_rise) else $error("release");
    property p_wr; $rose(WRITE_STROBE_N) && hit |-> ##[1:4] CORE_WR_STROBE; endproperty
    a_wr: assert property (p_wr) else $error("write");
    property p_one; CORE_WR_STROBE |=> !CORE_WR_STROBE; endproperty
    a_one: assert property (p_one) else $error("pulse");
    property p_lat; ADDR_STROBE_N && $past(ADDR_STROBE_N) |-> $stable(LOCAL_DEVICE_DECODE_N);
    endproperty
    a_lat: assert property (p_lat) else $error("latch");
    cover property (!ASYNC_READY_OUT);
    cover property (CORE_WR_STROBE);
    cover property (ADDR_STROBE_N && !LOCAL_DEVICE_DECODE_N);
endmodule
bind host_bus_byte_lane_port host_port_sva host_port_sva_i (.*);

/* File: sim/host_model.sv */
// host bus master model
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    input wire logic rdy,
    output logic [15:1] addr,
    output logic qual_n,
    output logic [3:0] be_n,
    output logic rd_n,
    output logic wr_n,
    output logic [31:0] wd
);
    initial {addr, qual_n, be_n, rd_n, wr_n, wd} = {15'h0, 7'h7f, 32'h0};
    task automatic xfer(input logic w, q, input logic [15:1] a, input logic [3:0] b,
        input logic [31:0] d, output logic hung);
        int n;
        @(posedge clk);
        {addr, qual_n, be_n, wd} <= {a, q, b, d};
        @(posedge clk);
        {rd_n, wr_n} <= {w, !w};
        repeat (3) @(posedge clk);
        for (n = 0; n < 40 && !rdy; n++) @(posedge clk);
        hung = !rdy;
        {rd_n, wr_n} <= 2'h3;
        @(posedge clk);
        // released data lines must not keep the old value
        {qual_n, wd} <= {1'b1, ~d};
    endtask
endmodule

/* File: sim/host_bus_byte_lane_port_test.sv */
// bench for the host bus byte lane port
`timescale 1ns/1ps
module host_bus_byte_lane_port_test;
    import host_port_pkg::*;
    localparam logic [15:1] HIT = 15'h0180;
    logic CLK = 0, RESETN = 0, MODE16 = 1, ADDR_STROBE_N = 0, CORE_BUSY = 0, hung, ld;
    logic IO_QUALIFY_N, READ_STROBE_N, WRITE_STROBE_N, ASYNC_READY_OUT;
    logic LOCAL_DEVICE_DECODE_N, CORE_WR_STROBE;
    logic [15:1] ADDR, CORE_ADDR;
    logic [3:0] BYTE_ENABLE_N, DATA_OE_N, CORE_WR_LANES, oe;
    logic [31:0] DATA_IN, DATA_OUT, CORE_WR_DATA, q, CORE_RD_DATA = 32'h4433_2211;
    xfer_size_t XFER_SIZE;
    int fails = 0, num_checks = 0, wr_count = 0;
    always #12.5 CLK = ~CLK;
    host_bus_byte_lane_port host_bus_byte_lane_port_i (.CLK(CLK), .RESETN(RESETN),
        .MODE16(MODE16), .ADDR(ADDR), .IO_QUALIFY_N(IO_QUALIFY_N),
        .BYTE_ENABLE_N(BYTE_ENABLE_N), .ADDR_STROBE_N(ADDR_STROBE_N),
        .READ_STROBE_N(READ_STROBE_N), .WRITE_STROBE_N(WRITE_STROBE_N),
        .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N),
        .ASYNC_READY_OUT(ASYNC_READY_OUT), .LOCAL_DEVICE_DECODE_N(LOCAL_DEVICE_DECODE_N),
        .CORE_BUSY(CORE_BUSY), .CORE_RD_DATA(CORE_RD_DATA), .CORE_ADDR(CORE_ADDR),
        .CORE_WR_DATA(CORE_WR_DATA), .CORE_WR_LANES(CORE_WR_LANES),
        .CORE_WR_STROBE(CORE_WR_STROBE), .XFER_SIZE(XFER_SIZE));
    host_model host_model_i (.clk(CLK), .rdy(ASYNC_READY_OUT), .addr(ADDR),
        .qual_n(IO_QUALIFY_N), .be_n(BYTE_ENABLE_N), .rd_n(READ_STROBE_N),
        .wr_n(WRITE_STROBE_N), .wd(DATA_IN));
    always @(posedge CLK) begin
        if (!READ_STROBE_N) {q, oe, ld} <= {DATA_OUT, DATA_OE_N, LOCAL_DEVICE_DECODE_N};
        if (CORE_WR_STROBE) wr_count <= wr_count + 1;
    end
    task automatic chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %h %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic acc(input logic w, qn, input logic [15:1] a, input logic [3:0] b);
        host_model_i.xfer(w, qn, a, b, 32'h1234_5678, hung);
        if (hung) begin
            fails++;
            tally_and_finish();
        end
    endtask
    task automatic t_read16;
        logic [3:0] t [4] = '{4'hc, 4'he, 4'hd, 4'hf};
        logic [31:0] m;
        foreach (t[i]) begin
            m = {16'h0, {8{!t[i][1]}}, {8{!t[i][0]}}};
            acc(1'b0, 1'b0, HIT, t[i]);
            chk({27'h0, oe, ld}, {27'h0, t[i], 1'b0});
            chk(q & m, CORE_RD_DATA & m);
        end
        $display("read16 end");
    endtask
    task automatic t_busy;
        CORE_BUSY <= 1'b1;
        fork
            acc(1'b0, 1'b0, HIT, 4'hc);
            begin
                repeat (8) @(posedge CLK);
                chk({31'h0, ASYNC_READY_OUT}, 32'h0);
                CORE_BUSY <= 1'b0;
            end
        join
        $display("busy end");
    endtask
    task automatic t_write;
        int n;
        n = wr_count;
        acc(1'b1, 1'b0, HIT, 4'he);
        repeat (6) @(posedge CLK);
        chk(wr_count, n + 1);
        chk({24'h0, CORE_WR_DATA[7:0]}, 32'h78);
        chk({28'h0, CORE_WR_LANES}, 32'h1);
        chk({17'h0, CORE_ADDR}, {17'h0, HIT});
        $display("write end");
    endtask
    task automatic t_read32;
        logic [3:0] t [7] = '{4'h0, 4'hc, 4'h3, 4'he, 4'hd, 4'hb, 4'h7};
        xfer_size_t e;
        foreach (t[i]) begin
            e = (i == 0) ? XFER_DWORD : (i < 3) ? XFER_WORD : XFER_BYTE;
            acc(1'b0, 1'b0, HIT, t[i]);
            chk({28'h0, oe}, {28'h0, t[i]});
            chk({29'h0, XFER_SIZE}, {29'h0, e});
        end
        $display("read32 end");
    endtask
    task automatic t_decode;
        acc(1'b0, 1'b1, HIT, 4'h0);
        chk({27'h0, oe, ld}, 32'h1f);
        acc(1'b0, 1'b0, 15'h0200, 4'h0);
        chk({27'h0, oe, ld}, 32'h1f);
        // close the latch mid-access, while the hit address and qualify still stand
        fork
            acc(1'b0, 1'b0, HIT, 4'h0);
            begin
                repeat (3) @(posedge CLK);
                ADDR_STROBE_N <= 1'b1;
            end
        join
        acc(1'b0, 1'b0, 15'h0200, 4'h0);
        chk({27'h0, oe, ld}, 32'h0);
        ADDR_STROBE_N <= 1'b0;
        $display("decode end");
    endtask
    initial begin
        repeat (20) @(posedge CLK);
        RESETN <= 1'b1;
        t_read16();
        t_busy();
        t_write();
        MODE16 <= 1'b0;
        t_read32();
        t_decode();
        tally_and_finish();
    end
endmodule
